// [inc/sdw_pkg.sv]
// package for the dual watchdog block: register map, resets, timing
`default_nettype none
package sdw_pkg;
    // register offsets (word registers, 16-bit data in low bits)
    localparam logic [3:0]  ADDR_MULT      = 4'h0;
    localparam logic [3:0]  ADDR_SM_TIME   = 4'h1;
    localparam logic [3:0]  ADDR_LAI_TIME  = 4'h2;
    localparam logic [3:0]  ADDR_STATUS    = 4'h3;
    localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_EN    = 4'h5;
    localparam logic [3:0]  ADDR_IRQ_CLR   = 4'h6;
    localparam logic [3:0]  ADDR_OUT_DATA  = 4'h7;
    // reset values
    localparam logic [15:0] MULT_RST       = 16'h09c2;
    localparam logic [15:0] SM_TIME_RST    = 16'h03e8;
    localparam logic [15:0] LAI_TIME_RST   = 16'h03e8;
    // tick lasts multiplier plus this many base periods
    localparam logic [15:0] TICK_EXTRA     = 16'h0002;
    // status / irq bit positions
    localparam int          BIT_SM_EXP     = 0;
    localparam int          BIT_LAI_EXP    = 1;
    localparam int          BIT_RUN        = 2;
    localparam int          IRQ_W          = 2;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } sdw_bus_req_t;
endpackage : sdw_pkg
`default_nettype wire

// [core/sdw_top.sv]
// dual watchdog: bus-side sync manager and local application interface
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
module sdw_top
    import sdw_pkg::*;
#(
    parameter int OUT_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire sdw_bus_req_t      bus_req,
    output var  logic [15:0]       rdata,
    input  wire logic              pd_exchange,
    input  wire logic              lai_access,
    input  wire logic              running_state,
    output var  logic [OUT_W-1:0]  outputs,
    output var  logic              sm_expired,
    output var  logic              lai_expired,
    output var  logic              irq
);

    // ========================================================
    // register writes
    logic [15:0]      mult;
    logic [15:0]      sm_time;
    logic [15:0]      lai_time;
    logic [IRQ_W-1:0] irq_en;
    logic [OUT_W-1:0] out_data;
    logic             wr_mult;
    logic             wr_sm;
    logic             wr_lai;
    logic             wr_clr;

    assign wr_mult = bus_req.wr && bus_req.addr == ADDR_MULT;
    assign wr_sm   = bus_req.wr && bus_req.addr == ADDR_SM_TIME;
    assign wr_lai  = bus_req.wr && bus_req.addr == ADDR_LAI_TIME;
    assign wr_clr  = bus_req.wr && bus_req.addr == ADDR_IRQ_CLR;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mult     <= MULT_RST;
            sm_time  <= SM_TIME_RST;
            lai_time <= LAI_TIME_RST;
            irq_en   <= '0;
            out_data <= '0;
        end else if (bus_req.wr) begin
            // a zero multiplier is out of range; hold the old value
            if (wr_mult && bus_req.wdata != 16'h0000) begin
                mult <= bus_req.wdata;
            end
            if (wr_sm) begin
                sm_time <= bus_req.wdata;
            end
            if (wr_lai) begin
                lai_time <= bus_req.wdata;
            end
            if (bus_req.addr == ADDR_IRQ_EN) begin
                irq_en <= bus_req.wdata[IRQ_W-1:0];
            end
            if (bus_req.addr == ADDR_OUT_DATA) begin
                out_data <= bus_req.wdata[OUT_W-1:0];
            end
        end
    end

    // ========================================================
    // shared prescaler
    logic [16:0] pre_cnt;
    logic        tick;
    logic [16:0] tick_last;

    // count 0..mult+1, that is mult+2 base periods per tick; one bit
    // wider than the multiplier so the largest setting does not wrap
    assign tick_last = {1'b0, mult} + 17'(TICK_EXTRA) - 17'h00001;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_cnt <= '0;
            tick    <= 1'b0;
        end else if (pre_cnt >= tick_last) begin
            pre_cnt <= '0;
            tick    <= 1'b1;
        end else begin
            pre_cnt <= 17'(pre_cnt + 17'h00001);
            tick    <= 1'b0;
        end
    end

    // ========================================================
    // bus-side watchdog
    logic [15:0] sm_cnt;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sm_cnt     <= '0;
            sm_expired <= 1'b0;
        end else if (sm_time == 16'h0000) begin
            sm_cnt     <= '0;
            sm_expired <= 1'b0;
        end else if (pd_exchange) begin
            sm_cnt     <= '0;
            sm_expired <= 1'b0;
        end else if (tick && !sm_expired) begin
            if (16'(sm_cnt + 16'h0001) >= sm_time) begin
                sm_expired <= 1'b1;
            end else begin
                sm_cnt <= 16'(sm_cnt + 16'h0001);
            end
        end
    end

    // ========================================================
    // local application interface watchdog
    logic [15:0] lai_cnt;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lai_cnt     <= '0;
            lai_expired <= 1'b0;
        end else if (lai_time == 16'h0000) begin
            lai_cnt     <= '0;
            lai_expired <= 1'b0;
        end else if (lai_access) begin
            lai_cnt     <= '0;
            lai_expired <= 1'b0;
        end else if (tick && !lai_expired) begin
            if (16'(lai_cnt + 16'h0001) >= lai_time) begin
                lai_expired <= 1'b1;
            end else begin
                lai_cnt <= 16'(lai_cnt + 16'h0001);
            end
        end
    end

    // ========================================================
    // process outputs, forced false on bus-side watchdog expiry only
    logic sm_fire;
    assign sm_fire = tick && !sm_expired && sm_time != 16'h0000
                     && !pd_exchange
                     && 16'(sm_cnt + 16'h0001) >= sm_time;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outputs <= '0;
        end else if (sm_expired || sm_fire) begin
            outputs <= '0;
        end else begin
            outputs <= out_data;
        end
    end

    // ========================================================
    // interrupts: sticky status, set wins over clear
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] ev;
    logic             lai_fire;

    assign lai_fire = tick && !lai_expired && lai_time != 16'h0000
                      && !lai_access
                      && 16'(lai_cnt + 16'h0001) >= lai_time;
    assign ev = {lai_fire, sm_fire};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_clr ? bus_req.wdata[IRQ_W-1:0]
                                             : {IRQ_W{1'b0}})) | ev;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_en);
        end
    end

    // ========================================================
    // read port
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_MULT:     rdata <= mult;
                ADDR_SM_TIME:  rdata <= sm_time;
                ADDR_LAI_TIME: rdata <= lai_time;
                ADDR_STATUS: begin
                    rdata              <= '0;
                    rdata[BIT_SM_EXP]  <= sm_expired;
                    rdata[BIT_LAI_EXP] <= lai_expired;
                    rdata[BIT_RUN]     <= running_state;
                end
                ADDR_IRQ_STAT: rdata <= {{(16-IRQ_W){1'b0}}, irq_stat};
                ADDR_IRQ_EN:   rdata <= {{(16-IRQ_W){1'b0}}, irq_en};
                ADDR_OUT_DATA: rdata <= 16'(out_data);
                default:       rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ========================================================
    // checks
    sm_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pd_exchange |=> !sm_expired && sm_cnt == 16'h0000)
        else $error("bus watchdog not restarted by exchange");

    sm_outputs_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sm_expired |=> outputs == '0)
        else $error("outputs not forced false after expiry");

    sm_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sm_time == 16'h0000 |=> !sm_expired)
        else $error("disabled bus watchdog expired");

    sm_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sm_expired && !pd_exchange && sm_time != 16'h0000
        |=> sm_expired)
        else $error("bus expired flag dropped without exchange");

    lai_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lai_expired && !lai_access && lai_time != 16'h0000
        |=> lai_expired)
        else $error("local expired flag dropped without access");

    tick_period_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(tick) |=> !tick ##1 !tick)
        else $error("tick spacing below minimum");

    mult_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        mult != 16'h0000)
        else $error("multiplier left its range");

    lai_trig_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lai_fire |=> lai_expired && irq_stat[1])
        else $error("local expiry not flagged");

    sm_cnt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !sm_expired && sm_time != 16'h0000 |-> sm_cnt < sm_time)
        else $error("bus count beyond timeout");

    // base periods since the last tick, for the spacing check; a
    // multiplier write restarts the measurement
    logic [16:0] gap_cnt;
    logic        gap_ok;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt <= '0;
            gap_ok  <= 1'b0;
        end else if (wr_mult) begin
            gap_cnt <= '0;
            gap_ok  <= 1'b0;
        end else if (tick) begin
            gap_cnt <= 17'h00001;
            gap_ok  <= 1'b1;
        end else begin
            gap_cnt <= 17'(gap_cnt + 17'h00001);
        end
    end

    tick_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick && gap_ok |-> gap_cnt == {1'b0, mult} + 17'(TICK_EXTRA))
        else $error("tick period differs from multiplier plus two");

    // expiry, output forcing and status side effects
    sm_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sm_fire |=> sm_expired && outputs == '0 && irq_stat[BIT_SM_EXP])
        else $error("bus expiry not flagged or outputs not forced");

    outputs_live_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !sm_expired && !sm_fire |=> outputs == $past(out_data))
        else $error("outputs not following the written value");

    run_status_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_req.rd && bus_req.addr == ADDR_STATUS
        |=> rdata[BIT_RUN] == $past(running_state)
            && rdata[BIT_SM_EXP] == $past(sm_expired))
        else $error("status read does not match live state");

    lai_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lai_access |=> !lai_expired && lai_cnt == 16'h0000)
        else $error("local watchdog not restarted by access");

    lai_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lai_time == 16'h0000 |=> !lai_expired)
        else $error("disabled local watchdog expired");

    lai_cnt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !lai_expired && lai_time != 16'h0000 |-> lai_cnt < lai_time)
        else $error("local count beyond timeout");

    mult_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_mult && bus_req.wdata == 16'h0000 |=> mult == $past(mult))
        else $error("zero multiplier write was taken");

    // register port and interrupt plumbing
    irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        irq == $past(|(irq_stat & irq_en)))
        else $error("interrupt level does not follow enabled status");

    irq_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_clr && bus_req.wdata[BIT_SM_EXP] && !sm_fire
        |=> !irq_stat[BIT_SM_EXP])
        else $error("bus status bit not cleared by write");

    rd_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !bus_req.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");

    rd_mult_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_req.rd && bus_req.addr == ADDR_MULT |=> rdata == $past(mult))
        else $error("multiplier read back wrong");

    sm_expire_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(sm_expired));
    lai_expire_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(lai_expired));
    sm_recover_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        sm_expired ##1 pd_exchange);
    irq_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(irq));
    lai_recover_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        lai_expired ##1 lai_access);

endmodule : sdw_top
`default_nettype wire

// [sim/sdw_partner.sv]
// far-side model: fieldbus master exchanges and local processor accesses
`default_nettype none
module sdw_partner (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic pd_on,
    input  wire logic lai_on,
    output var  logic pd_exchange,
    output var  logic lai_access
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ph;
    // ====
    // both parties talk every other cycle while switched on
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph          <= 1'b0;
            pd_exchange <= 1'b0;
            lai_access  <= 1'b0;
        end else begin
            ph          <= ~ph;
            pd_exchange <= pd_on & ph;
            lai_access  <= lai_on & ~ph;
        end
    end
endmodule : sdw_partner
`default_nettype wire

// [sim/sdw_top_bench.sv]
// bench for the dual watchdog: bus tasks, partner and scenarios
`default_nettype none
module sdw_top_bench import sdw_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic         sys_clk = 1'b0;
    logic         rst_b   = 1'b0;
    sdw_bus_req_t bus_req = '0;
    logic         run     = 1'b1;
    logic         pd_on   = 1'b1;
    logic         lai_on  = 1'b1;
    logic [15:0]  rdata;
    logic         pd_exchange;
    logic         lai_access;
    logic [7:0]   outputs;
    logic         sm_expired;
    logic         lai_expired;
    logic         irq;
    int           err_count = 0;
    int           tests_run = 0;

    always #12.5 sys_clk = ~sys_clk;

    sdw_partner peer_u (.sys_clk(sys_clk), .rst_b(rst_b), .pd_on(pd_on),
        .lai_on(lai_on), .pd_exchange(pd_exchange), .lai_access(lai_access));
    sdw_top #(.OUT_W(8)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .bus_req(bus_req), .rdata(rdata), .pd_exchange(pd_exchange),
        .lai_access(lai_access), .running_state(run), .outputs(outputs),
        .sm_expired(sm_expired), .lai_expired(lai_expired), .irq(irq));

    // ====
    // common tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [15:0] e, got);
        tests_run++;
        if (got !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e, string nm);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask : rd

    // counts edges until the chosen flag reaches v; window lo..hi
    task automatic wfor(input logic sel, v, input int lo, hi);
        int n;
        n = 0;
        while ((sel ? lai_expired : sm_expired) !== v) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > hi) begin
                chk("flag wait", 16'(hi), 16'(n));
                end_sim();
            end
        end
        chk("flag early", 16'h0001, 16'(n >= lo));
    endtask : wfor

    // ====
    // scenarios
    task automatic sc_defaults();
        rd(ADDR_MULT, 16'h09c2, "mult");
        rd(ADDR_SM_TIME, 16'h03e8, "sm time");
        rd(ADDR_LAI_TIME, 16'h03e8, "lai time");
        wr(ADDR_MULT, 16'h0000);
        rd(ADDR_MULT, 16'h09c2, "mult zero");
        rd(4'hf, 16'h0000, "unmapped");
    endtask : sc_defaults

    task automatic sc_config();
        wr(ADDR_MULT, 16'h0001);
        wr(ADDR_SM_TIME, 16'h0005);
        wr(ADDR_LAI_TIME, 16'h0003);
        wr(ADDR_OUT_DATA, 16'h00a5);
        wr(ADDR_IRQ_EN, 16'h0003);
        rd(ADDR_MULT, 16'h0001, "mult set");
        chk("outputs live", 16'h00a5, {8'h00, outputs});
    endtask : sc_config

    task automatic sc_sm_expiry();
        @(posedge sys_clk);
        pd_on <= 1'b0;
        wfor(1'b0, 1'b1, 12, 18);
        chk("outputs safe", 16'h0000, {8'h00, outputs});
        repeat (20) @(posedge sys_clk);
        #1;
        chk("sm held", 16'h0001, {15'h0, sm_expired});
        chk("lai quiet", 16'h0000, {15'h0, lai_expired});
        chk("irq", 16'h0001, {15'h0, irq});
        rd(ADDR_STATUS, 16'h0005, "status");
        @(posedge sys_clk);
        pd_on <= 1'b1;
        wfor(1'b0, 1'b0, 1, 4);
        @(posedge sys_clk);
        #1;
        chk("outputs back", 16'h00a5, {8'h00, outputs});
        wr(ADDR_IRQ_CLR, 16'h0003);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq cleared", 16'h0000, {15'h0, irq});
    endtask : sc_sm_expiry

    task automatic sc_lai_expiry();
        @(posedge sys_clk);
        lai_on <= 1'b0;
        wfor(1'b1, 1'b1, 6, 12);
        chk("sm quiet", 16'h0000, {15'h0, sm_expired});
        rd(ADDR_IRQ_STAT, 16'h0002, "irq stat lai");
        chk("irq lai", 16'h0001, {15'h0, irq});
        @(posedge sys_clk);
        lai_on <= 1'b1;
        wfor(1'b1, 1'b0, 1, 4);
    endtask : sc_lai_expiry

    task automatic sc_disable();
        wr(ADDR_SM_TIME, 16'h0000);
        wr(ADDR_LAI_TIME, 16'h0000);
        @(posedge sys_clk);
        pd_on  <= 1'b0;
        lai_on <= 1'b0;
        run    <= 1'b0;
        repeat (40) @(posedge sys_clk);
        #1;
        chk("sm off", 16'h0000, {15'h0, sm_expired});
        chk("outputs kept", 16'h00a5, {8'h00, outputs});
        chk("lai off", 16'h0000, {15'h0, lai_expired});
        rd(ADDR_STATUS, 16'h0000, "status idle");
        wr(ADDR_MULT, 16'hffff);
        rd(ADDR_MULT, 16'hffff, "mult max");
    endtask : sc_disable

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        sc_defaults();
        sc_config();
        sc_sm_expiry();
        sc_lai_expiry();
        sc_disable();
        end_sim();
    end
endmodule : sdw_top_bench
`default_nettype wire
